/* File: design/cdr_pkg.sv */
package cdr_pkg;

  // ----------------------------------------------------------------------
  // Register map (printed offsets are word indices; byte address = 4*idx)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_GLOBAL_CFG   = 8'h06;
  localparam logic [7:0] IDX_LEVEL_HIGH   = 8'h07;
  localparam logic [7:0] IDX_LEVEL_LOW    = 8'h08;
  localparam logic [7:0] IDX_CH0_SETUP    = 8'h09;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h21;
  localparam logic [7:0] IDX_DET_STATUS   = 8'h22;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_GLOBAL_CFG  = 16'h0600;
  localparam logic [15:0] RST_LEVEL_HIGH  = 16'h0000;
  localparam logic [15:0] RST_LEVEL_LOW   = 16'h0000;
  localparam logic [15:0] RST_CH0_SETUP   = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_ON_BIT      = 0;
  localparam int CFG_WIN_LSB     = 1;
  localparam int CFG_CNT_LSB     = 4;
  localparam int CFG_POLICY_BIT  = 7;
  localparam int LOW_DC_LSB      = 0;
  localparam int LOW_LVL_LSB     = 8;
  localparam int CH0_MUX_LSB     = 0;
  localparam int CH0_DCOFF_BIT   = 2;
  localparam int CH0_SKEW_LSB    = 6;

  // Writable bit masks; everything else reads as zero
  localparam logic [15:0] MASK_LEVEL_LOW  = 16'hff0f;
  localparam logic [15:0] MASK_CH0_SETUP  = 16'hffc7;

  // Interrupt bits
  localparam int IRQ_DETECT_BIT  = 0;
  localparam int IRQ_WINDOW_BIT  = 1;
  localparam int IRQ_WIDTH       = 2;

  // Input selection codes
  typedef enum logic [1:0] {
    CDR_IN_PINS, CDR_IN_SHORT, CDR_IN_POS_TEST, CDR_IN_NEG_TEST
  } cdr_input_type;

endpackage : cdr_pkg

/* File: design/cdr_regs.sv */
// Implementation choice: the APB register port.
`timescale 1ns/100ps
// Functional notes
// - Count selector bits 6:4 pick 1..128 exceedances
// - Window selector bits 3:1 pick period count
// - Bit 0 turns detect mode on
// - Threshold is upper sixteen plus low byte
// - Low register bits 7:4 read zero
// - Low register bits 3:0 global DC setting
// - Channel 0 bits 15:6 signed skew
// - Channel 0 bits 5:3 read zero
// - Channel 0 bit 2 bypasses DC filter
// - Channel 0 bits 1:0 pick input source
// - Bit 7 chooses any or all channels
module cdr_regs #(
  parameter int NCH = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                conv_done,
  input  wire logic [NCH-1:0]      ch_exceed,
  output logic                     detect_mode_on,
  output logic [2:0]               exceed_count_sel,
  output logic [2:0]               detect_window_sel,
  output logic                     detect_channel_policy,
  output logic [23:0]              detect_level,
  output logic [3:0]               dc_removal_setting,
  output logic [9:0]               ch0_sample_skew,
  output logic                     ch0_dc_removal_off,
  output logic                     ch0_dc_removal_active,
  output logic [1:0]               ch0_input_select,
  output logic                     detect_flag,
  output logic                     irq
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  // Channel vector is reduced in one cycle; wider sets are not served
  if (NCH < 1 || NCH > 16) begin : g_bad_nch
    $error("cdr_regs: NCH must be 1..16");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    // Software-visible registers
    logic [15:0]                   cfg;
    logic [15:0]                   lvl_hi;
    logic [15:0]                   lvl_lo;
    logic [15:0]                   ch0;
    // Interrupt status and mask
    logic [1:0]                    irq_stat;
    logic [1:0]                    irq_mask;
    // Detector progress within the current window
    logic [11:0]                   win_cnt;
    logic [7:0]                    hit_cnt;
    logic                          detected;
    logic                          win_done;
    // Read data held for the access phase
    logic [31:0]                   rdata;
  } cdr_state_type;

  cdr_state_type st_q;
  cdr_state_type st_d;
  // One-cycle event made from the detection level
  logic          det_pulse;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Window length in conversion periods
  function automatic logic [11:0] cdr_window_len(input logic [2:0] sel);
    logic [11:0] len;
    len = 12'h080;
    unique case (sel)
      3'h0: len = 12'h080;
      3'h1: len = 12'h100;
      3'h2: len = 12'h200;
      3'h3: len = 12'h300;
      3'h4: len = 12'h500;
      3'h5: len = 12'h700;
      3'h6: len = 12'ha00;
      3'h7: len = 12'he00;
    endcase
    return len;
  endfunction : cdr_window_len

  // Exceedance target is a power of two, one to 128
  function automatic logic [8:0] cdr_hit_target(input logic [2:0] sel);
    logic [8:0] tgt;
    tgt = 9'h001;
    unique case (sel)
      3'h0: tgt = 9'h001;
      3'h1: tgt = 9'h002;
      3'h2: tgt = 9'h004;
      3'h3: tgt = 9'h008;
      3'h4: tgt = 9'h010;
      3'h5: tgt = 9'h020;
      3'h6: tgt = 9'h040;
      3'h7: tgt = 9'h080;
    endcase
    return tgt;
  endfunction : cdr_hit_target

  // Words that answer on the bus; every other index is refused
  function automatic logic cdr_reg_mapped(input logic [7:0] i);
    logic ok;
    ok = 1'b0;
    unique case (i)
      cdr_pkg::IDX_GLOBAL_CFG,
      cdr_pkg::IDX_LEVEL_HIGH,
      cdr_pkg::IDX_LEVEL_LOW,
      cdr_pkg::IDX_CH0_SETUP,
      cdr_pkg::IDX_IRQ_STATUS,
      cdr_pkg::IDX_IRQ_MASK,
      cdr_pkg::IDX_DET_STATUS: ok = 1'b1;
      default:                 ok = 1'b0;
    endcase
    return ok;
  endfunction : cdr_reg_mapped

  // Byte-lane merge honouring pstrb on the low 16 bits
  function automatic logic [15:0] cdr_merge(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb,
                                            input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & mask;
  endfunction : cdr_merge

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic [7:0]  idx;
  logic        hit;
  logic        exceed_now;

  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign idx    = paddr[9:2];
  // Unaligned or unmapped addresses answer with an error
  assign hit    = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h000000) &&
                  cdr_reg_mapped(idx);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  // Any-channel or all-channel exceedance
  assign exceed_now = st_q.cfg[cdr_pkg::CFG_POLICY_BIT] ?
                      (&ch_exceed) : (|ch_exceed);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [11:0] win_len;
    logic [8:0]  target;
    logic        last;
    // Hold everything unless a branch below says otherwise
    st_d    = st_q;
    win_len = cdr_window_len(st_q.cfg[cdr_pkg::CFG_WIN_LSB +: 3]);
    target  = cdr_hit_target(st_q.cfg[cdr_pkg::CFG_CNT_LSB +: 3]);
    last    = 1'b0;
    // Window-end event lasts a single cycle
    st_d.win_done = 1'b0;

    // Detector runs only while the mode is on; off clears progress
    if (!st_q.cfg[cdr_pkg::CFG_ON_BIT]) begin
      st_d.win_cnt  = 12'h000;
      st_d.hit_cnt  = 8'h00;
      st_d.detected = 1'b0;
    end else if (conv_done) begin
      // At or past the end, so a window shortened mid-run still closes
      last = (st_q.win_cnt >= win_len - 12'h001);
      // One hit per conversion; counting stops once detected
      if (exceed_now && !st_q.detected) begin
        if ({1'b0, st_q.hit_cnt} + 9'h001 >= target) begin
          st_d.detected = 1'b1;
        end
        st_d.hit_cnt = st_q.hit_cnt + 8'h01;
      end
      // Window boundary: detection is per window, not sticky
      if (last) begin
        st_d.win_cnt  = 12'h000;
        st_d.hit_cnt  = 8'h00;
        st_d.detected = 1'b0;
        st_d.win_done = 1'b1;
      end else begin
        st_d.win_cnt = st_q.win_cnt + 12'h001;
      end
    end

    // Register writes
    if (wr && hit) begin
      unique case (idx)
        cdr_pkg::IDX_GLOBAL_CFG: begin
          st_d.cfg = cdr_merge(st_q.cfg, pwdata, pstrb, 16'hffff);
        end
        cdr_pkg::IDX_LEVEL_HIGH: begin
          st_d.lvl_hi = cdr_merge(st_q.lvl_hi, pwdata, pstrb, 16'hffff);
        end
        cdr_pkg::IDX_LEVEL_LOW: begin
          st_d.lvl_lo = cdr_merge(st_q.lvl_lo, pwdata, pstrb,
                                  cdr_pkg::MASK_LEVEL_LOW);
        end
        cdr_pkg::IDX_CH0_SETUP: begin
          st_d.ch0 = cdr_merge(st_q.ch0, pwdata, pstrb,
                               cdr_pkg::MASK_CH0_SETUP);
        end
        // Write one to clear
        cdr_pkg::IDX_IRQ_STATUS: begin
          if (pstrb[0]) begin
            st_d.irq_stat = st_q.irq_stat & ~pwdata[1:0];
          end
        end
        cdr_pkg::IDX_IRQ_MASK: begin
          if (pstrb[0]) begin
            st_d.irq_mask = pwdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Set wins over a simultaneous write-one clear
    if (det_pulse) begin
      st_d.irq_stat[cdr_pkg::IRQ_DETECT_BIT] = 1'b1;
    end
    if (st_q.win_done) begin
      st_d.irq_stat[cdr_pkg::IRQ_WINDOW_BIT] = 1'b1;
    end

    // Read data registered in the setup cycle, presented in access;
    // refused addresses read as zero
    st_d.rdata = 32'h00000000;
    if (psel && !penable && !pwrite && hit) begin
      unique case (idx)
        cdr_pkg::IDX_GLOBAL_CFG: st_d.rdata = {16'h0000, st_q.cfg};
        cdr_pkg::IDX_LEVEL_HIGH: st_d.rdata = {16'h0000, st_q.lvl_hi};
        cdr_pkg::IDX_LEVEL_LOW:  st_d.rdata = {16'h0000, st_q.lvl_lo};
        cdr_pkg::IDX_CH0_SETUP:  st_d.rdata = {16'h0000, st_q.ch0};
        cdr_pkg::IDX_IRQ_STATUS: st_d.rdata = {30'h0, st_q.irq_stat};
        cdr_pkg::IDX_IRQ_MASK:   st_d.rdata = {30'h0, st_q.irq_mask};
        cdr_pkg::IDX_DET_STATUS: st_d.rdata = {11'h000, st_q.detected,
                                               st_q.hit_cnt, st_q.win_cnt};
        default:                 st_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Register fields start from their reset values
      st_q.cfg      <= cdr_pkg::RST_GLOBAL_CFG;
      st_q.lvl_hi   <= cdr_pkg::RST_LEVEL_HIGH;
      st_q.lvl_lo   <= cdr_pkg::RST_LEVEL_LOW;
      st_q.ch0      <= cdr_pkg::RST_CH0_SETUP;
      // Interrupts quiet and masked
      st_q.irq_stat <= 2'h0;
      st_q.irq_mask <= 2'h0;
      // Detector idle at the start of a window
      st_q.win_cnt  <= 12'h000;
      st_q.hit_cnt  <= 8'h00;
      st_q.detected <= 1'b0;
      st_q.win_done <= 1'b0;
      // No read data outside an access
      st_q.rdata    <= 32'h00000000;
    end else begin
      st_q <= st_d;
    end
  end

  // Turns the per-window detection level into a one-cycle event
  cdr_sync_pulse u_det_edge (
    .pclk      (pclk),
    .presetn   (presetn),
    .level_in  (st_q.detected),
    .pulse_out (det_pulse)
  );

  // ----------------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------------
  // Read data comes straight from a flip-flop
  assign prdata                = st_q.rdata;

  // ----------------------------------------------------------------------
  // Detector configuration outputs
  // ----------------------------------------------------------------------
  // Plain field taps of the configuration word
  assign detect_mode_on        = st_q.cfg[cdr_pkg::CFG_ON_BIT];
  assign exceed_count_sel      = st_q.cfg[cdr_pkg::CFG_CNT_LSB +: 3];
  assign detect_window_sel     = st_q.cfg[cdr_pkg::CFG_WIN_LSB +: 3];
  assign detect_channel_policy = st_q.cfg[cdr_pkg::CFG_POLICY_BIT];
  // Full signed threshold, upper word above low byte
  assign detect_level          = {st_q.lvl_hi,
                                  st_q.lvl_lo[cdr_pkg::LOW_LVL_LSB +: 8]};
  assign dc_removal_setting    = st_q.lvl_lo[cdr_pkg::LOW_DC_LSB +: 4];

  // ----------------------------------------------------------------------
  // Channel 0 outputs
  // ----------------------------------------------------------------------
  // Skew is signed; the user extends the sign where needed
  assign ch0_sample_skew       = st_q.ch0[cdr_pkg::CH0_SKEW_LSB +: 10];
  assign ch0_dc_removal_off    = st_q.ch0[cdr_pkg::CH0_DCOFF_BIT];
  // Channel follows global setting unless bypassed
  assign ch0_dc_removal_active = ~st_q.ch0[cdr_pkg::CH0_DCOFF_BIT] &
                                 (|dc_removal_setting);
  assign ch0_input_select      = st_q.ch0[cdr_pkg::CH0_MUX_LSB +: 2];

  // ----------------------------------------------------------------------
  // Detector status and interrupt
  // ----------------------------------------------------------------------
  // Interrupt is a level that follows status and mask
  assign detect_flag           = st_q.detected;
  assign irq                   = |(st_q.irq_stat & st_q.irq_mask);

endmodule : cdr_regs

/* File: design/cdr_sync_pulse.sv */
`timescale 1ns/100ps
// Registers an event level into a one-cycle pulse on its rising edge.
module cdr_sync_pulse (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level_in,
  output logic      pulse_out
);

  logic level_q;

  // ----------------------------------------------------------------------
  // Edge detect
  // ----------------------------------------------------------------------
  // Registered output keeps the pulse glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q   <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      level_q   <= level_in;
      pulse_out <= level_in & ~level_q;
    end
  end

endmodule : cdr_sync_pulse

/* File: verification/cdr_regs_monitor.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Register field checker
// ----------------------------------------------------------------------
module cdr_regs_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        detect_mode_on,
  input wire logic [2:0]  exceed_count_sel,
  input wire logic [2:0]  detect_window_sel,
  input wire logic [23:0] detect_level,
  input wire logic [3:0]  dc_removal_setting,
  input wire logic [9:0]  ch0_sample_skew,
  input wire logic        ch0_dc_removal_off,
  input wire logic        ch0_dc_removal_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded access phases; full byte address compare on purpose
  logic wr_cfg, wr_hi, wr_low, rd_low, rd_ch0;
  assign wr_cfg = psel && penable && pwrite && paddr == 32'h18 && pstrb[0];
  assign wr_hi  = psel && penable && pwrite && paddr == 32'h1c
                  && pstrb[1:0] == 2'b11;
  assign wr_low = psel && penable && pwrite && paddr == 32'h20 && pstrb[0];
  assign rd_low = psel && penable && !pwrite && paddr == 32'h20;
  assign rd_ch0 = psel && penable && !pwrite && paddr == 32'h24;
  property p_cnt;
    wr_cfg |=> exceed_count_sel == $past(pwdata[6:4]);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count field");
  property p_win;
    wr_cfg |=> detect_window_sel == $past(pwdata[3:1]);
  endproperty
  a_win: assert property (p_win) else $error("window field");
  property p_on;
    wr_cfg |=> detect_mode_on == $past(pwdata[0]);
  endproperty
  a_on: assert property (p_on) else $error("mode bit");
  property p_hi;
    wr_hi |=> detect_level[23:8] == $past(pwdata[15:0]);
  endproperty
  a_hi: assert property (p_hi) else $error("upper level");
  property p_rdlow;
    rd_low |-> prdata[7:4] == 4'h0 && prdata[15:8] == detect_level[7:0];
  endproperty
  a_rdlow: assert property (p_rdlow) else $error("low read");
  property p_dc;
    wr_low |=> dc_removal_setting == $past(pwdata[3:0]);
  endproperty
  a_dc: assert property (p_dc) else $error("dc setting");
  property p_rdch0;
    rd_ch0 |-> prdata[5:3] == 3'h0 && prdata[15:6] == ch0_sample_skew;
  endproperty
  a_rdch0: assert property (p_rdch0) else $error("ch0 read");
  property p_byp;
    ch0_dc_removal_active == (!ch0_dc_removal_off && dc_removal_setting != 0);
  endproperty
  a_byp: assert property (p_byp) else $error("dc bypass");
endmodule : cdr_regs_checker

bind cdr_regs cdr_regs_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .detect_mode_on(detect_mode_on), .exceed_count_sel(exceed_count_sel),
  .detect_window_sel(detect_window_sel), .detect_level(detect_level),
  .dc_removal_setting(dc_removal_setting),
  .ch0_sample_skew(ch0_sample_skew),
  .ch0_dc_removal_off(ch0_dc_removal_off),
  .ch0_dc_removal_active(ch0_dc_removal_active));

/* File: verification/cdr_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module cdr_regs_tb;
  logic        pclk, presetn, psel, penable, pwrite, conv_done;
  logic [31:0] paddr, pwdata, prdata, rd, v;
  logic [3:0]  pstrb, dc;
  logic [7:0]  ch_exceed;
  logic        pready, err, pslverr, on, pol, cd_off, cd_act, flag, irq;
  logic [2:0]  cnt, win;
  logic [23:0] lvl;
  logic [9:0]  skew;
  logic [1:0]  mux;
  logic [31:0] ra [4] = '{32'h18, 32'h1c, 32'h20, 32'h24};
  logic [31:0] rv [4] = '{32'h0600, 32'h0, 32'h0, 32'h0};
  int          failures = 0;
  int          tests_run = 0;

  cdr_regs #(.NCH(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_done(conv_done), .ch_exceed(ch_exceed), .detect_mode_on(on),
    .exceed_count_sel(cnt), .detect_window_sel(win),
    .detect_channel_policy(pol), .detect_level(lvl),
    .dc_removal_setting(dc), .ch0_sample_skew(skew),
    .ch0_dc_removal_off(cd_off), .ch0_dc_removal_active(cd_act),
    .ch0_input_select(mux), .detect_flag(flag), .irq(irq));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // One APB transfer; request held until pready seen high at an edge
  task automatic apb(input logic w, input logic [31:0] a, d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Conversion pulses, one clock wide with a gap between
  task automatic cv(input int n);
    repeat (n) begin
      @(posedge pclk);
      conv_done <= 1'b1;
      @(posedge pclk);
      conv_done <= 1'b0;
    end
  endtask : cv

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, conv_done} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ch_exceed = 8'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0, 4'h0);
      `CHK(rd, rv[i])
    end
    $display("test reset values done");
    apb(1'b1, 32'h20, 32'hffff, 4'hf);
    apb(1'b0, 32'h20, 32'h0, 4'h0);
    `CHK(rd, 32'hff0f)
    apb(1'b1, 32'h1c, 32'h8001, 4'hf);
    @(negedge pclk);
    `CHK(lvl, 24'h8001ff)
    `CHK(dc, 4'hf)
    $display("test threshold done");
    for (int m = 0; m < 4; m++) begin
      v = {16'h0, 10'h2a5 ^ 10'(m), 3'b111, m[0], m[1:0]};
      apb(1'b1, 32'h24, v, 4'h3);
      @(negedge pclk);
      `CHK(mux, m[1:0])
      `CHK(skew, 10'h2a5 ^ 10'(m))
      `CHK(cd_act, ~m[0])
      `CHK(cd_off, m[0])
      apb(1'b0, 32'h24, 32'h0, 4'h0);
      `CHK(rd, v & 32'hffc7)
    end
    $display("test channel zero done");
    for (int k = 0; k < 8; k++) begin
      v = {16'h0, 8'h06, k[0], k[2:0], ~k[2:0], k[0]};
      apb(1'b1, 32'h18, v, 4'h3);
      @(negedge pclk);
      `CHK(cnt, k[2:0])
      `CHK(win, ~k[2:0])
      `CHK(on, k[0])
      `CHK(pol, k[0])
    end
    $display("test config codes done");
    // Two hits needed, 128-period window, one channel is enough
    apb(1'b1, 32'h84, 32'h0, 4'h1);
    apb(1'b1, 32'h18, 32'h0611, 4'h3);
    ch_exceed <= 8'h01;
    cv(1);
    @(negedge pclk);
    `CHK(flag, 1'b0)
    cv(1);
    @(negedge pclk);
    `CHK(flag, 1'b1)
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, 32'h84, 32'h1, 4'h1);
    @(negedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b0, 32'h80, 32'h0, 4'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, 32'h80, 32'h1, 4'h1);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    cv(125);
    @(negedge pclk);
    `CHK(flag, 1'b1)
    cv(1);
    @(negedge pclk);
    `CHK(flag, 1'b0)
    repeat (2) @(posedge pclk);
    apb(1'b0, 32'h80, 32'h0, 4'h0);
    `CHK(rd, 32'h2)
    // All channels must exceed once bit 7 is set; one hit is enough
    apb(1'b1, 32'h18, 32'h0681, 4'h3);
    cv(1);
    @(negedge pclk);
    `CHK(flag, 1'b0)
    @(posedge pclk);
    ch_exceed <= 8'hff;
    cv(1);
    @(negedge pclk);
    `CHK(flag, 1'b1)
    $display("test detection done");
    apb(1'b0, 32'h40, 32'h0, 4'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    // Unaligned word of a mapped register is refused too
    apb(1'b0, 32'h22, 32'h0, 4'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    $display("test unmapped done");
    final_report();
  end

  // Watchdog far beyond the expected four microseconds
  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule : cdr_regs_tb
